// *** rtl/sar_adc_channel_sequencer.sv ***
// SAR converter channel sequencer with AHB-Lite register slave.
// Assumes an analog SAR comparator answering each trial within one hclk cycle.
//
// Behaviour
// - Conversion clock enable is divided from hclk to at most 18 MHz.
// - Each conversion spans at least eighteen conversion clocks including sampling.
// - Reference select picks supply, half supply, internal reference or external pin.
// - Sample window length is programmable.
// - An eight-channel input multiplexer feeds the converter.
// - Scan mode steps through every enabled channel without software.
// - Next channel starts immediately with no dead cycles.
// - Control bit picks state-machine or firmware channel selection.
// - Each channel keeps its latest result in its own buffer.
// - Each channel has its own sample time, applied when sampled.
// - Every result is compared to programmable low and high limits.
// - Out-of-range interrupt raised immediately on a violating result.
// - Temperature sensor selectable as converter input.
// - Conversions stop while the chip is in deep low-power modes.
// - Optional averaging of repeated samples per channel.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_channel_sequencer
   import sar_seq_pkg::*;
(
   // Clock and reset
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   // AHB-Lite slave
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   // Analog front end
   output logic      [2:0]                 mux_sel,
   output logic                            temp_sel,
   output logic      [1:0]                 ref_sel,
   output logic                            sample_en,
   output logic      [RES_W-1:0]           dac_code,
   input  wire logic                       cmp_in,
   // Power and interrupt
   input  wire logic                       deep_sleep,
   output logic                            irq
);
   import sar_seq_pkg::*;

   typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} st_t;

   ////////////////////////////////////////////////////////////////
   // Synchronisers for comparator and power-mode level
   logic [1:0] cmp_s_r, slp_s_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_s_r <= 2'b00;
         slp_s_r <= 2'b00;
      end else begin
         cmp_s_r <= {cmp_s_r[0], cmp_in};
         slp_s_r <= {slp_s_r[0], deep_sleep};
      end
   end
   wire logic cmp    = cmp_s_r[1];
   wire logic asleep = slp_s_r[1];

   ////////////////////////////////////////////////////////////////
   // Conversion clock enable divider
   logic [3:0] div_r, div_nxt;
   logic       cen;
   always_comb begin
      cen     = (div_r == 4'(CDIV - 1));
      div_nxt = cen ? 4'h0 : div_r + 4'h1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) div_r <= 4'h0;
      else          div_r <= div_nxt;
   end

   ////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0]      ctrl_r, ctrl_nxt, limit_r, limit_nxt;
   logic [7:0]       chen_r, chen_nxt;
   logic [2:0]       stat_r, stat_nxt, mask_r, mask_nxt;
   logic [7:0]       smp_r [NCH], smp_nxt [NCH];
   logic [RES_W-1:0] res_r [NCH], res_nxt [NCH];
   logic             wr_ph_r, rd_ph_r;
   logic [7:0]       ofs_r;

   // Sequencer state
   st_t              st_r, st_nxt;
   logic [2:0]       ch_r, ch_nxt;
   logic [7:0]       cnt_r, cnt_nxt;
   logic [3:0]       bit_r, bit_nxt;
   logic [RES_W-1:0] sar_r, sar_nxt;
   logic [6:0]       avg_r, avg_nxt;
   logic [RES_W+7:0] acc_r, acc_nxt;

   function automatic logic [2:0] next_ch(input logic [2:0] c, input logic [7:0] en);
      logic [2:0] n;
      n = c;
      for (int i = 1; i <= NCH; i++) begin
         if (en[3'(c + 3'(i))] && n == c) n = 3'(c + 3'(i));
      end
      return n;
   endfunction

   function automatic logic is_last(input logic [2:0] c, input logic [7:0] en);
      logic l;
      l = 1'b1;
      for (int i = 0; i < NCH; i++) begin
         if (en[i] && 3'(i) > c) l = 1'b0;
      end
      return l;
   endfunction

   wire logic       fw_mode = ctrl_r[C_FWSEL];
   wire logic [2:0] avg_log = ctrl_r[C_AVG_LO +: 3];
   wire logic       addr_ok = hsel && htrans[1] && hready;
   logic            done_ev, eos_ev, rng_ev;
   logic [RES_W-1:0] avg_val;

   always_comb begin
      ctrl_nxt  = ctrl_r;
      limit_nxt = limit_r;
      chen_nxt  = chen_r;
      mask_nxt  = mask_r;
      smp_nxt   = smp_r;
      // Start stands until the next converter tick
      if (cen) ctrl_nxt[C_START] = 1'b0;
      if (wr_ph_r) begin
         unique case (ofs_r)
            CTRL_OFS:  ctrl_nxt  = hwdata;
            MASK_OFS:  mask_nxt  = hwdata[2:0];
            LIMIT_OFS: limit_nxt = hwdata;
            CHEN_OFS:  chen_nxt  = hwdata[7:0];
            default: begin
               if (ofs_r[7:5] == SMP_OFS[7:5] && ofs_r[1:0] == 2'b00)
                  smp_nxt[ofs_r[4:2]] = hwdata[7:0];
            end
         endcase
      end
      // Sticky status: set wins over read-clear
      stat_nxt = (rd_ph_r && ofs_r == STAT_OFS) ? 3'b000 : stat_r;
      stat_nxt = stat_nxt | {rng_ev, eos_ev, done_ev};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r  <= CTRL_RST;
         limit_r <= LIMIT_RST;
         chen_r  <= CHEN_RST;
         mask_r  <= 3'b000;
         stat_r  <= 3'b000;
         wr_ph_r <= 1'b0;
         rd_ph_r <= 1'b0;
         ofs_r   <= 8'h00;
         for (int i = 0; i < NCH; i++) smp_r[i] <= MIN_SAMPLE;
      end else begin
         ctrl_r  <= ctrl_nxt;
         limit_r <= limit_nxt;
         chen_r  <= chen_nxt;
         mask_r  <= mask_nxt;
         stat_r  <= stat_nxt;
         smp_r   <= smp_nxt;
         wr_ph_r <= addr_ok && hwrite;
         rd_ph_r <= addr_ok && !hwrite;
         if (addr_ok) ofs_r <= haddr[7:0];
      end
   end

   // Read data, combinational in the data phase
   always_comb begin
      hrdata = 32'h0;
      if (rd_ph_r) begin
         if (ofs_r == CTRL_OFS)       hrdata = ctrl_r;
         else if (ofs_r == STAT_OFS)  hrdata = {29'h0, stat_r};
         else if (ofs_r == MASK_OFS)  hrdata = {29'h0, mask_r};
         else if (ofs_r == LIMIT_OFS) hrdata = limit_r;
         else if (ofs_r == CHEN_OFS)  hrdata = {24'h0, chen_r};
         else if (ofs_r[7:5] == SMP_OFS[7:5] && ofs_r[1:0] == 2'b00)
            hrdata = {24'h0, smp_r[ofs_r[4:2]]};
         else if (ofs_r[7:5] == RES_OFS[7:5] && ofs_r[1:0] == 2'b00)
            hrdata = {20'h0, res_r[ofs_r[4:2]]};
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(stat_r & mask_r);

   ////////////////////////////////////////////////////////////////
   // Conversion sequencer
   wire logic run   = ctrl_r[C_EN] && !asleep;
   wire logic go    = ctrl_r[C_START] || ctrl_r[C_CONT];
   wire logic [2:0] first_ch = fw_mode ? ctrl_r[C_FWCH_LO +: 3]
                                       : next_ch(3'h7, chen_r);
   wire logic [RES_W-1:0] trial = sar_r | (12'h800 >> bit_r);

   always_comb begin
      st_nxt  = st_r;
      ch_nxt  = ch_r;
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      sar_nxt = sar_r;
      avg_nxt = avg_r;
      acc_nxt = acc_r;
      res_nxt = res_r;
      done_ev = 1'b0;
      eos_ev  = 1'b0;
      rng_ev  = 1'b0;
      avg_val = RES_W'(acc_r >> avg_log);
      if (!run) begin
         st_nxt = IDLE;
      end else if (cen) begin
         unique case (st_r)
            IDLE: begin
               if (go && (fw_mode || chen_r != 8'h00)) begin
                  st_nxt  = SAMPLE;
                  ch_nxt  = first_ch;
                  cnt_nxt = 8'h00;
                  avg_nxt = 7'h0;
                  acc_nxt = '0;
               end
            end
            SAMPLE: begin
               // Window widened so total reaches the minimum cycles
               if (cnt_r + 8'h1 >= smp_r[ch_r] && cnt_r + 8'h1 >= 8'(CONV_CYC - SAR_BITS)) begin
                  st_nxt  = CONVERT;
                  bit_nxt = 4'h0;
                  sar_nxt = '0;
               end else begin
                  cnt_nxt = cnt_r + 8'h1;
               end
            end
            CONVERT: begin
               if (cmp) sar_nxt = trial;
               bit_nxt = bit_r + 4'h1;
               if (bit_r == 4'(SAR_BITS - 1)) begin
                  sar_nxt = cmp ? trial : sar_r;
                  acc_nxt = acc_r + (RES_W+8)'(sar_nxt);
                  avg_nxt = avg_r + 7'h1;
                  st_nxt  = SAMPLE;
                  cnt_nxt = 8'h00;
                  if (avg_r == 7'((1 << avg_log) - 1)) begin
                     avg_val = RES_W'(acc_nxt >> avg_log);
                     res_nxt[ch_r] = avg_val;
                     done_ev = 1'b1;
                     rng_ev  = (avg_val < limit_r[11:0]) || (avg_val > limit_r[27:16]);
                     avg_nxt = 7'h0;
                     acc_nxt = '0;
                     if (fw_mode) begin
                        ch_nxt = ctrl_r[C_FWCH_LO +: 3];
                        st_nxt = ctrl_r[C_CONT] ? SAMPLE : IDLE;
                     end else if (is_last(ch_r, chen_r)) begin
                        eos_ev = 1'b1;
                        ch_nxt = first_ch;
                        st_nxt = ctrl_r[C_CONT] ? SAMPLE : IDLE;
                     end else begin
                        ch_nxt = next_ch(ch_r, chen_r);
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r  <= IDLE;
         ch_r  <= 3'h0;
         cnt_r <= 8'h00;
         bit_r <= 4'h0;
         sar_r <= '0;
         avg_r <= 7'h0;
         acc_r <= '0;
         for (int i = 0; i < NCH; i++) res_r[i] <= '0;
      end else begin
         st_r  <= st_nxt;
         ch_r  <= ch_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         sar_r <= sar_nxt;
         avg_r <= avg_nxt;
         acc_r <= acc_nxt;
         res_r <= res_nxt;
      end
   end

   // Converter clocks spent on the current conversion
   logic [7:0] span_r, span_nxt;
   always_comb begin
      span_nxt = span_r;
      if (st_r == IDLE || (cen && st_r == CONVERT && bit_r == 4'(SAR_BITS - 1))) span_nxt = 8'h00;
      else if (cen && span_r != 8'hff) span_nxt = span_r + 8'h1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) span_r <= 8'h00;
      else          span_r <= span_nxt;
   end

   assign mux_sel   = ch_r;
   assign temp_sel  = ctrl_r[C_TEMP];
   assign ref_sel   = ctrl_r[C_REF_LO +: 2];
   assign sample_en = (st_r == SAMPLE);
   assign dac_code  = (st_r == CONVERT) ? trial : sar_r;

   ////////////////////////////////////////////////////////////////
   // Checks
   a_sleep_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      asleep |=> st_r == IDLE) else $error("converter active in sleep");
   a_range_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      rng_ev |=> stat_r[S_RANGE]) else $error("range flag missed");
   a_eos_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      eos_ev |=> stat_r[S_EOS]) else $error("end of scan missed");
   a_no_gap: assert property (@(posedge hclk) disable iff (!hresetn)
      (done_ev && !eos_ev && !fw_mode && run) |=> st_r == SAMPLE) else $error("dead cycle between channels");
   a_min_conv: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == IDLE ##1 st_r == SAMPLE) |-> st_r != CONVERT [*6]) else $error("sample too short");
   a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      (rng_ev && mask_nxt[S_RANGE]) |=> irq) else $error("unmasked range event without irq");
   a_result_store: assert property (@(posedge hclk) disable iff (!hresetn)
      done_ev |=> res_r[$past(ch_r)] == $past(avg_val)) else $error("result not buffered");
   a_div_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      cen |=> !cen) else $error("conversion clock too fast");
   a_scan_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (done_ev && !fw_mode && !eos_ev) |=> chen_r[ch_r]) else $error("stepped to disabled channel");
   a_conv_span: assert property (@(posedge hclk) disable iff (!hresetn)
      (cen && st_r == CONVERT && bit_r == 4'(SAR_BITS - 1)) |-> span_r >= 8'(CONV_CYC - 1))
      else $error("conversion shorter than minimum");
endmodule
`default_nettype wire

// *** inc/sar_seq_pkg.sv ***
// Constants for the SAR channel sequencer: register map, fields, timing.
// Assumes a 20 MHz bus clock; the converter clock is derived by a divider.
package sar_seq_pkg;
   localparam int          NCH        = 8;
   localparam int          RES_W      = 12;
   localparam int          CLK_HZ     = 20_000_000;
   localparam int          CONV_MAX_HZ = 18_000_000;
   // Divider: never above the maximum rate, and slow enough
   // for each trial code to clear the comparator synchroniser
   localparam int          CDIV_MIN   = (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
   localparam int          CMP_LAT    = 2;
   localparam int          CDIV       = (CDIV_MIN > CMP_LAT) ? CDIV_MIN : CMP_LAT + 1;
   localparam int          CONV_CYC   = 18;
   localparam int          SAR_BITS   = 12;
   localparam logic [7:0]  MIN_SAMPLE = 8'h06;
   // Register byte offsets
   localparam logic [7:0]  CTRL_OFS   = 8'h00;
   localparam logic [7:0]  STAT_OFS   = 8'h04;
   localparam logic [7:0]  MASK_OFS   = 8'h08;
   localparam logic [7:0]  LIMIT_OFS  = 8'h0c;
   localparam logic [7:0]  CHEN_OFS   = 8'h10;
   localparam logic [7:0]  SMP_OFS    = 8'h20;
   localparam logic [7:0]  RES_OFS    = 8'h40;
   // Control fields
   localparam int          C_EN       = 0;
   localparam int          C_START    = 1;
   localparam int          C_CONT     = 2;
   localparam int          C_FWSEL    = 3;
   localparam int          C_REF_LO   = 4;
   localparam int          C_AVG_LO   = 8;
   localparam int          C_FWCH_LO  = 12;
   localparam int          C_TEMP     = 16;
   // Status bits
   localparam int          S_DONE     = 0;
   localparam int          S_EOS      = 1;
   localparam int          S_RANGE    = 2;
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RST  = 32'h0fff_0000;
   localparam logic [7:0]  CHEN_RST   = 8'h01;
   typedef enum logic [1:0] {REF_VDD, REF_HALF, REF_INT, REF_EXT} ref_t;
endpackage

// *** sim/sar_front_model.sv ***
// Behavioural analog front end: eight channel inputs and a temperature sensor.
// Assumes the sequencer synchronizes cmp_in itself; the comparator answers at once.
`timescale 1ns/1ns
`default_nettype none
module sar_front_model #(
   parameter logic [11:0] TEMP_V = 12'h5a5
)
(
   // Input selection
   input  wire logic [2:0]                   mux_sel,
   input  wire logic                         temp_sel,
   // Comparator
   input  wire logic [sar_seq_pkg::RES_W-1:0] dac_code,
   output logic                              cmp_in
);
   import sar_seq_pkg::*;
   logic [RES_W-1:0] vin;
   // Input level sits half a step above its code
   always_comb begin
      vin = temp_sel ? TEMP_V : 12'h123 + 12'(mux_sel) * 12'h1d1;
      cmp_in = {vin, 1'b1} > {dac_code, 1'b0};
   end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the SAR channel sequencer over AHB-Lite.
// Assumes a zero-wait slave and the behavioural analog front end model.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sar_seq_pkg::*;
   localparam logic [31:0] GO = (32'h1 << C_EN) | (32'h1 << C_START);
   localparam logic [31:0] FW = 32'h1 << C_FWSEL;
   logic        hclk, hresetn, hsel, hwrite, deep_sleep, cmp_in;
   logic        hreadyout, hresp, temp_sel, sample_en, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, ref_sel;
   logic [2:0]  hsize, mux_sel;
   logic [11:0] dac_code;
   int          fails, num_checks;

   sar_adc_channel_sequencer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mux_sel(mux_sel), .temp_sel(temp_sel),
      .ref_sel(ref_sel), .sample_en(sample_en), .dac_code(dac_code), .cmp_in(cmp_in),
      .deep_sleep(deep_sleep), .irq(irq));
   sar_front_model fe (.mux_sel(mux_sel), .temp_sel(temp_sel), .dac_code(dac_code), .cmp_in(cmp_in));

   always #25 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] chv(input int n);
      return {20'h0, 12'h123 + 12'(n) * 12'h1d1};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b0;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk(nm, hrdata, e);
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge hclk);
         n++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rc("ctrl", CTRL_OFS, CTRL_RST);
      rc("limit", LIMIT_OFS, LIMIT_RST);
      rc("chen", CHEN_OFS, {24'h0, CHEN_RST});
      rc("smp3", SMP_OFS + 8'h0c, {24'h0, MIN_SAMPLE});
      rc("unmapped", 8'h80, 32'h0);
      chk("irq_idle", {31'h0, irq}, 32'h0);
      for (int r = 0; r < 4; r++) begin
         wr(CTRL_OFS, 32'(r) << C_REF_LO);
         @(posedge hclk);
         chk("ref_sel", {30'h0, ref_sel}, 32'(r));
      end
      $display("test reset done");
   endtask
   task automatic t_scan;
      int n;
      wr(MASK_OFS, 32'h1 << S_EOS);
      wr(CHEN_OFS, 32'h89);
      wr(SMP_OFS + 8'h0c, 32'h10);
      wr(CTRL_OFS, GO);
      wait_irq(n);
      chk("scan_time", {31'h0, n >= 64 * CDIV + 2 && n <= 65 * CDIV + 1}, 32'h1);
      rc("stat_eos", STAT_OFS, 32'h3);
      rc("stat_clr", STAT_OFS, 32'h0);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      rc("res0", RES_OFS, chv(0));
      rc("res3", RES_OFS + 8'h0c, chv(3));
      rc("res7", RES_OFS + 8'h1c, chv(7));
      $display("test scan done");
   endtask
   task automatic t_range;
      int n;
      wr(SMP_OFS + 8'h0c, 32'h6);
      wr(LIMIT_OFS, 32'h0600_0200);
      wr(MASK_OFS, 32'h1 << S_RANGE);
      wr(CTRL_OFS, GO);
      wait_irq(n);
      chk("range_early", {31'h0, n >= 18 * CDIV + 2 && n <= 19 * CDIV + 1}, 32'h1);
      rc("stat_range", STAT_OFS, 32'h5);
      wr(MASK_OFS, 32'h1 << S_EOS);
      wait_irq(n);
      rc("range_eos", STAT_OFS, 32'h7);
      $display("test range done");
   endtask
   task automatic t_fw;
      int n;
      wr(LIMIT_OFS, LIMIT_RST);
      wr(MASK_OFS, 32'h1 << S_DONE);
      rc("stat_pre", STAT_OFS, 32'h0);
      for (int t = 0; t < 2; t++) begin
         wr(CTRL_OFS, GO | FW | (32'h5 << C_FWCH_LO) | (32'(t) << C_TEMP));
         repeat (CDIV + 1) @(posedge hclk);
         chk("fw_sampling", {31'h0, sample_en}, 32'h1);
         wait_irq(n);
         chk("fw_mux", {29'h0, mux_sel}, 32'h5);
         chk("fw_idle", {31'h0, sample_en}, 32'h0);
         chk("temp_sel", {31'h0, temp_sel}, 32'(t));
         rc("fw_stat", STAT_OFS, 32'h1);
         rc("fw_res", RES_OFS + 8'h14, t == 1 ? 32'h5a5 : chv(5));
      end
      $display("test firmware done");
   endtask
   task automatic t_avg;
      int n;
      wr(CHEN_OFS, 32'h01);
      wr(CTRL_OFS, GO | (32'h4 << C_AVG_LO));
      wait_irq(n);
      chk("avg_time", {31'h0, n >= 288 * CDIV + 2 && n <= 289 * CDIV + 1}, 32'h1);
      rc("avg_res", RES_OFS, chv(0));
      rc("avg_stat", STAT_OFS, 32'h3);
      $display("test averaging done");
   endtask
   task automatic t_sleep;
      int n;
      deep_sleep <= 1'b1;
      wr(CTRL_OFS, GO);
      repeat (200) @(posedge hclk);
      chk("sleep_irq", {31'h0, irq}, 32'h0);
      chk("sleep_smp", {31'h0, sample_en}, 32'h0);
      rc("sleep_stat", STAT_OFS, 32'h0);
      deep_sleep <= 1'b0;
      wr(CTRL_OFS, GO);
      wait_irq(n);
      rc("wake_stat", STAT_OFS, 32'h3);
      $display("test sleep done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      deep_sleep = 1'b0;
      fails = 0;
      num_checks = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_scan();
      t_range();
      t_fw();
      t_avg();
      t_sleep();
      test_done();
   end
   initial begin
      #1000000;
      fails++;
      test_done();
   end
endmodule
`default_nettype wire
